// ===== sync_dynamic_termination_ctl.sv
`timescale 1ns/1ps

module sync_dynamic_termination_ctl #(
  parameter int depth = term_ctl_pkg::pipe_depth
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory link pins
  input wire logic mem_clk,
  input wire logic termination_control_pin,
  input wire logic write_cmd,
  input wire logic read_cmd,
  input wire logic burst_chop_four,
  // termination outputs
  output logic [2:0] term_strength,
  output logic [1:0] term_select,
  output logic term_enable
);

  logic [31:0] ctrl_q;
  logic [31:0] mode_one_q;
  logic [31:0] mode_two_q;
  logic [31:0] mode_five_q;

  // sampled link inputs, three stages each
  logic [2:0] clk_s_q;
  logic [2:0] pin_s_q;
  logic [2:0] wr_s_q;
  logic [2:0] rd_s_q;
  logic [2:0] bc_s_q;
  logic pin_lvl_q;
  logic edge_q;

  // axi write channel state
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // link cycle pipeline
  logic [depth-1:0] nom_pipe_q;
  logic [depth-1:0] wr_on_pipe_q;
  logic [depth-1:0] wr_off_pipe_q;
  logic [depth-1:0] rd_off_pipe_q;
  logic [depth-1:0] rd_on_pipe_q;
  logic wr_act_q;
  logic rd_act_q;
  logic nom_act_q;

  localparam int lat_w_c = term_ctl_pkg::lat_w;
  logic two_pre;
  logic sync_mode;
  logic dyn_en;
  logic [lat_w_c-1:0] wl;
  logic [lat_w_c-1:0] base_lat;
  logic [lat_w_c-1:0] wr_rel;
  logic [lat_w_c-1:0] rd_rel;

  function automatic logic field_sel(input logic [7:0] a, input logic [7:0] off);
    field_sel = (a[7:2] == off[7:2]);
  endfunction : field_sel

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic pipe_tap(input logic [depth-1:0] p, input logic [lat_w_c-1:0] lat);
    pipe_tap = (lat == '0) ? 1'b0 : p[lat - 6'h01];
  endfunction : pipe_tap

  // latency arithmetic
  assign two_pre = ctrl_q[term_ctl_pkg::two_pre_bit];
  assign sync_mode = ctrl_q[term_ctl_pkg::dll_en_bit] & ctrl_q[term_ctl_pkg::dll_lock_bit];
  assign dyn_en = sync_mode & (mode_two_q[9] | mode_two_q[10]);
  assign wl = ctrl_q[term_ctl_pkg::cas_wl_lsb +: lat_w_c] + ctrl_q[term_ctl_pkg::add_lat_lsb +: lat_w_c]
    + ctrl_q[term_ctl_pkg::par_lat_lsb +: lat_w_c];
  assign base_lat = wl - (two_pre ? term_ctl_pkg::lat_two_pre : term_ctl_pkg::lat_one_pre);

  // write release offset by chop, crc and preamble
  always_comb
  begin
    if (bc_s_q[2])
    begin
      if (ctrl_q[term_ctl_pkg::crc_bit])
      begin
        wr_rel = two_pre ? term_ctl_pkg::rel_eight : term_ctl_pkg::rel_seven;
      end
      else
      begin
        wr_rel = two_pre ? term_ctl_pkg::rel_chop_two : term_ctl_pkg::rel_chop;
      end
    end
    else if (ctrl_q[term_ctl_pkg::crc_bit] && two_pre)
    begin
      wr_rel = term_ctl_pkg::rel_eight;
    end
    else if (ctrl_q[term_ctl_pkg::crc_bit] || two_pre)
    begin
      wr_rel = term_ctl_pkg::rel_seven;
    end
    else
    begin
      wr_rel = term_ctl_pkg::rel_full;
    end
  end

  // read re-enable offset, burst over two plus preamble margin
  always_comb
  begin
    if (bc_s_q[2])
    begin
      rd_rel = two_pre ? term_ctl_pkg::rel_chop_two : term_ctl_pkg::rel_chop;
    end
    else
    begin
      rd_rel = two_pre ? term_ctl_pkg::rel_seven : term_ctl_pkg::rel_full;
    end
  end

  // link input sampling and mem_clk rising edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_s_q <= '0;
      pin_s_q <= '0;
      wr_s_q <= '0;
      rd_s_q <= '0;
      bc_s_q <= '0;
      pin_lvl_q <= 1'b0;
      edge_q <= 1'b0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[1:0], mem_clk};
      pin_s_q <= {pin_s_q[1:0], termination_control_pin};
      wr_s_q <= {wr_s_q[1:0], write_cmd};
      rd_s_q <= {rd_s_q[1:0], read_cmd};
      bc_s_q <= {bc_s_q[1:0], burst_chop_four};
      edge_q <= (clk_s_q[2:1] == 2'b01);
      if (pin_s_q[2] == pin_s_q[1])
      begin
        pin_lvl_q <= pin_s_q[2];
      end
    end
  end

  // request delay lines, one shift per link cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sync_mode)
    begin
      nom_pipe_q <= '0;
      wr_on_pipe_q <= '0;
      wr_off_pipe_q <= '0;
      rd_off_pipe_q <= '0;
      rd_on_pipe_q <= '0;
    end
    else if (edge_q)
    begin
      nom_pipe_q <= {nom_pipe_q[depth-2:0], pin_lvl_q};
      wr_on_pipe_q <= {wr_on_pipe_q[depth-2:0], wr_s_q[2] & dyn_en};
      wr_off_pipe_q <= {wr_off_pipe_q[depth-2:0], 1'b0};
      rd_off_pipe_q <= {rd_off_pipe_q[depth-2:0], rd_s_q[2]};
      rd_on_pipe_q <= {rd_on_pipe_q[depth-2:0], 1'b0};
      if (wr_s_q[2] && dyn_en)
      begin
        // placed so that it reaches the top bit after the full release latency
        wr_off_pipe_q <= {wr_off_pipe_q[depth-2:0], 1'b0}
          | (depth'(1) << (depth - (int'(base_lat) + int'(wr_rel))));
      end
      if (rd_s_q[2])
      begin
        rd_on_pipe_q <= {rd_on_pipe_q[depth-2:0], 1'b0}
          | (depth'(1) << (depth - (int'(base_lat) + int'(rd_rel))));
      end
    end
  end

  // override windows, nominal follows pin with direct latency
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sync_mode)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      nom_act_q <= 1'b0;
    end
    else if (edge_q)
    begin
      nom_act_q <= (base_lat == '0) ? pin_lvl_q : pipe_tap(nom_pipe_q, base_lat);
      if (wr_off_pipe_q[depth-1])
      begin
        wr_act_q <= 1'b0;
      end
      else if (pipe_tap(wr_on_pipe_q, base_lat))
      begin
        wr_act_q <= 1'b1;
      end
      if (rd_on_pipe_q[depth-1])
      begin
        rd_act_q <= 1'b0;
      end
      else if (pipe_tap(rd_off_pipe_q, base_lat))
      begin
        rd_act_q <= 1'b1;
      end
    end
  end

  // termination output, one aclk after the latency expires
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      term_select <= term_ctl_pkg::sel_off;
      term_strength <= '0;
      term_enable <= 1'b0;
    end
    else if (rd_act_q)
    begin
      term_select <= term_ctl_pkg::sel_off;
      term_strength <= '0;
      term_enable <= 1'b0;
    end
    else if (wr_act_q)
    begin
      term_select <= term_ctl_pkg::sel_wr;
      term_strength <= mode_two_q[term_ctl_pkg::wr_lsb +: term_ctl_pkg::str_w];
      term_enable <= 1'b1;
    end
    else if (nom_act_q && mode_one_q[term_ctl_pkg::nom_lsb +: term_ctl_pkg::str_w] != '0)
    begin
      term_select <= term_ctl_pkg::sel_nom;
      term_strength <= mode_one_q[term_ctl_pkg::nom_lsb +: term_ctl_pkg::str_w];
      term_enable <= 1'b1;
    end
    else
    begin
      term_select <= term_ctl_pkg::sel_park;
      term_strength <= mode_five_q[term_ctl_pkg::park_lsb +: term_ctl_pkg::str_w];
      term_enable <= (mode_five_q[term_ctl_pkg::park_lsb +: term_ctl_pkg::str_w] != '0);
    end
  end

  // axi write address and data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_held_q && w_held_q)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // register writes and write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= term_ctl_pkg::ctrl_rst;
      mode_one_q <= term_ctl_pkg::mode_rst;
      mode_two_q <= term_ctl_pkg::mode_rst;
      mode_five_q <= term_ctl_pkg::mode_rst;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= term_ctl_pkg::resp_okay;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (aw_held_q && w_held_q)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= term_ctl_pkg::resp_okay;
        if (field_sel(aw_addr_q, term_ctl_pkg::ctrl_off))
        begin
          ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
        end
        else if (field_sel(aw_addr_q, term_ctl_pkg::mode_one_off))
        begin
          mode_one_q <= merge(mode_one_q, w_data_q, w_strb_q);
        end
        else if (field_sel(aw_addr_q, term_ctl_pkg::mode_two_off))
        begin
          mode_two_q <= merge(mode_two_q, w_data_q, w_strb_q);
        end
        else if (field_sel(aw_addr_q, term_ctl_pkg::mode_five_off))
        begin
          mode_five_q <= merge(mode_five_q, w_data_q, w_strb_q);
        end
        else if (!field_sel(aw_addr_q, term_ctl_pkg::status_off))
        begin
          s_axi_bresp <= term_ctl_pkg::resp_slverr;
        end
      end
    end
  end

  // register reads
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= term_ctl_pkg::resp_okay;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= term_ctl_pkg::resp_okay;
        s_axi_rdata <= '0;
        if (field_sel(s_axi_araddr, term_ctl_pkg::ctrl_off))
        begin
          s_axi_rdata <= ctrl_q;
        end
        else if (field_sel(s_axi_araddr, term_ctl_pkg::mode_one_off))
        begin
          s_axi_rdata <= mode_one_q;
        end
        else if (field_sel(s_axi_araddr, term_ctl_pkg::mode_two_off))
        begin
          s_axi_rdata <= mode_two_q;
        end
        else if (field_sel(s_axi_araddr, term_ctl_pkg::mode_five_off))
        begin
          s_axi_rdata <= mode_five_q;
        end
        else if (field_sel(s_axi_araddr, term_ctl_pkg::status_off))
        begin
          s_axi_rdata <= {24'h000000, dyn_en, sync_mode, nom_act_q, wr_act_q, rd_act_q,
            term_enable, term_select};
        end
        else
        begin
          s_axi_rresp <= term_ctl_pkg::resp_slverr;
        end
      end
    end
  end

endmodule : sync_dynamic_termination_ctl

// ===== term_ctl_pkg.sv
package term_ctl_pkg;

  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] mode_one_off = 8'h04;
  localparam logic [7:0] mode_two_off = 8'h08;
  localparam logic [7:0] mode_five_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;

  // control register fields
  localparam int dll_en_bit = 0;
  localparam int dll_lock_bit = 1;
  localparam int two_pre_bit = 2;
  localparam int crc_bit = 3;
  localparam int cas_wl_lsb = 8;
  localparam int add_lat_lsb = 16;
  localparam int par_lat_lsb = 24;
  localparam int lat_w = 6;

  // mode register fields
  localparam int nom_lsb = 8;
  localparam int wr_lsb = 9;
  localparam int park_lsb = 6;
  localparam int str_w = 3;

  // reset values
  localparam logic [31:0] ctrl_rst = 32'h0000_0903;
  localparam logic [31:0] mode_rst = 32'h0000_0000;

  // latency offsets and write and read release margins
  localparam logic [lat_w-1:0] lat_one_pre = 6'h02;
  localparam logic [lat_w-1:0] lat_two_pre = 6'h03;
  localparam logic [lat_w-1:0] rel_chop = 6'h04;
  localparam logic [lat_w-1:0] rel_chop_two = 6'h05;
  localparam logic [lat_w-1:0] rel_full = 6'h06;
  localparam logic [lat_w-1:0] rel_seven = 6'h07;
  localparam logic [lat_w-1:0] rel_eight = 6'h08;

  // pipeline depth for delayed requests
  localparam int pipe_depth = 64;

  // mapped and unmapped address answers
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // termination selection
  typedef enum logic [1:0] {sel_off, sel_park, sel_nom, sel_wr} term_sel_t;

endpackage : term_ctl_pkg

// ===== term_ctl_properties.sv
`timescale 1ns/1ps
module term_ctl_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // termination outputs
  input wire logic [2:0] term_strength,
  input wire logic [1:0] term_select,
  input wire logic term_enable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst_quiet;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && term_select == 2'h0 && !term_enable && term_strength == 3'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared by reset");
  property p_off_quiet;
    term_select == term_ctl_pkg::sel_off |-> term_strength == 3'h0 && !term_enable;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("termination applied while off");
  property p_enable_code;
    term_select != term_ctl_pkg::sel_off |-> term_enable == (term_strength != 3'h0);
  endproperty
  a_enable_code: assert property (p_enable_code) else $error("enable disagrees with strength");
  property p_wr_strength;
    term_select == term_ctl_pkg::sel_wr |-> term_strength != 3'h0;
  endproperty
  a_wr_strength: assert property (p_wr_strength) else $error("write select without strength");
  property p_sel_spacing;
    $changed(term_select) |=> $stable(term_select) [*3];
  endproperty
  a_sel_spacing: assert property (p_sel_spacing) else $error("select changed twice per link edge");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_latency;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_latency: assert property (p_r_latency) else $error("read data late");
  property p_b_latency;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid;
  endproperty
  a_b_latency: assert property (p_b_latency) else $error("write response late");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read accepted");
endmodule : term_ctl_properties

bind sync_dynamic_termination_ctl term_ctl_properties term_ctl_properties_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .term_strength, .term_select, .term_enable);

// ===== mem_ctl_model.sv
`timescale 1ns/1ps
module mem_ctl_model (
  // link pins
  output logic mem_clk,
  output logic termination_control_pin,
  output logic write_cmd,
  output logic read_cmd,
  output logic burst_chop_four
);
  logic [1:0] pend_kind;
  logic pend_chop;
  int pin_left;
  initial
  begin
    mem_clk = 1'b0;
    termination_control_pin = 1'b0;
    write_cmd = 1'b0;
    read_cmd = 1'b0;
    burst_chop_four = 1'b0;
    pend_kind = 2'h0;
    pend_chop = 1'b0;
    pin_left = 0;
    #3;
    forever #40 mem_clk = ~mem_clk;
  end
  // lines change on the falling edge, one command per link edge
  always @(negedge mem_clk)
  begin
    write_cmd <= pend_kind == 2'h1;
    read_cmd <= pend_kind == 2'h2;
    burst_chop_four <= (pend_kind != 2'h0) ? pend_chop : ~burst_chop_four;
    termination_control_pin <= pin_left != 0;
    if (pin_left != 0)
      pin_left--;
    pend_kind = 2'h0;
  end
  task issue(input logic [1:0] kind, input logic chop, input int hold);
    @(posedge mem_clk);
    pend_kind = kind;
    pend_chop = chop;
    pin_left = (hold != 0 && hold < (chop ? 4 : 6)) ? (chop ? 4 : 6) : hold;
  endtask : issue
endmodule : mem_ctl_model

// ===== sync_dynamic_termination_ctl_bench.sv
`timescale 1ns/1ps
module sync_dynamic_termination_ctl_bench;
  typedef struct {logic [1:0] kind; logic chop; logic [31:0] ctrl; int lat; int rel;} row_t;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, term_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mem_clk, termination_control_pin, write_cmd, read_cmd, burst_chop_four, term_enable;
  logic [2:0] term_strength;
  logic [5:0] term_v;
  int n_mismatch = 0;
  int n_tests = 0;
  row_t rows [13];
  assign term_v = {term_select, term_strength, term_enable};
  sync_dynamic_termination_ctl sync_dynamic_termination_ctl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mem_clk, .termination_control_pin, .write_cmd, .read_cmd, .burst_chop_four,
    .term_strength, .term_select, .term_enable);
  mem_ctl_model mem_ctl_model_inst (.mem_clk, .termination_control_pin, .write_cmd, .read_cmd, .burst_chop_four);
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd
  task run_case(input logic [1:0] kind, input logic chop, input int hold, input int lat, input int rel);
    logic [5:0] win;
    win = (kind == 2'h1) ? {term_ctl_pkg::sel_wr, 3'h2, 1'b1} :
      (kind == 2'h2) ? 6'h00 : {term_ctl_pkg::sel_nom, 3'h3, 1'b1};
    mem_ctl_model_inst.issue(kind, chop, hold);
    @(posedge mem_clk);
    for (int k = 1; k <= rel + 2; k++)
    begin
      @(posedge mem_clk);
      chk("termination", term_v, (k > lat && k <= rel) ? win : {term_ctl_pkg::sel_park, 3'h1, 1'b1});
    end
  endtask : run_case
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    #300000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    rows = '{'{2'h1, 1'b0, 32'h0000_0903, 7, 13},
      '{2'h1, 1'b1, 32'h0000_0903, 7, 11},
      '{2'h1, 1'b1, 32'h0000_090b, 7, 14},
      '{2'h1, 1'b1, 32'h0000_0907, 6, 11},
      '{2'h1, 1'b1, 32'h0000_090f, 6, 14},
      '{2'h1, 1'b0, 32'h0000_090b, 7, 14},
      '{2'h1, 1'b0, 32'h0000_0907, 6, 13},
      '{2'h1, 1'b0, 32'h0000_090f, 6, 14},
      '{2'h2, 1'b1, 32'h0000_0903, 7, 11},
      '{2'h2, 1'b0, 32'h0000_0907, 6, 13},
      '{2'h2, 1'b0, 32'h0102_0903, 10, 16},
      '{2'h0, 1'b0, 32'h0000_0903, 7, 13},
      '{2'h0, 1'b0, 32'h0001_0907, 7, 14}};
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("reset term", term_v, {term_ctl_pkg::sel_park, 3'h0, 1'b0});
    for (int i = 0; i < 4; i++)
    begin
      axi_rd(8'(i * 4));
      chk("reset reg", rd, (i == 0) ? term_ctl_pkg::ctrl_rst : term_ctl_pkg::mode_rst);
    end
    axi_rd(8'h14);
    chk("unmapped read", 32'(rsp), 32'(term_ctl_pkg::resp_slverr));
    axi_wr(8'h14, 32'hffff_ffff);
    chk("unmapped write", 32'(rsp), 32'(term_ctl_pkg::resp_slverr));
    axi_wr(term_ctl_pkg::status_off, 32'hffff_ffff);
    chk("status write", 32'(rsp), 32'(term_ctl_pkg::resp_okay));
    axi_wr(term_ctl_pkg::mode_one_off, 32'h0000_0300);
    axi_wr(term_ctl_pkg::mode_two_off, 32'h0000_0400);
    axi_wr(term_ctl_pkg::mode_five_off, 32'h0000_0040);
    foreach (rows[i])
    begin
      axi_wr(term_ctl_pkg::ctrl_off, rows[i].ctrl);
      run_case(rows[i].kind, rows[i].chop, (rows[i].kind == 2'h0) ? rows[i].rel - rows[i].lat : 0, rows[i].lat, rows[i].rel);
    end
    axi_wr(term_ctl_pkg::ctrl_off, 32'h0000_0903);
    mem_ctl_model_inst.issue(2'h1, 1'b1, 6);
    repeat (10) @(posedge mem_clk);
    chk("overlap write", term_v, {term_ctl_pkg::sel_wr, 3'h2, 1'b1});
    repeat (3) @(posedge mem_clk);
    chk("overlap nominal", term_v, {term_ctl_pkg::sel_nom, 3'h3, 1'b1});
    repeat (4) @(posedge mem_clk);
    axi_wr(term_ctl_pkg::mode_two_off, 32'h0000_0000);
    run_case(2'h1, 1'b0, 0, 20, 20);
    axi_wr(term_ctl_pkg::mode_two_off, 32'h0000_0400);
    axi_wr(term_ctl_pkg::ctrl_off, 32'h0000_0901);
    run_case(2'h1, 1'b0, 0, 20, 20);
    final_report();
  end
endmodule : sync_dynamic_termination_ctl_bench
